// [logic/sdac_map.vh]
`ifndef SDAC_MAP_VH
`define SDAC_MAP_VH
// serial word layout
`define SDAC_WORD_W 16
`define SDAC_CNT_W 5
`define SDAC_WORD_LAST 5'h0f
`define SDAC_CNT_RST 5'h00
`define SDAC_WORD_RST 16'h0000
// data field is right-justified
`define SDAC_DATA_W 14
`define SDAC_RES_12 1'b0
`define SDAC_RES_14 1'b1
// output delay after a sampled serial clock fall, in ns
`define SDAC_OUT_DELAY_NS 16
`define SDAC_CLK_NS 8
`define SDAC_OUT_DELAY_CYC ((`SDAC_OUT_DELAY_NS + `SDAC_CLK_NS - 1) / `SDAC_CLK_NS)
// fifo of received words
`define SDAC_FIFO_DEPTH 32
`define SDAC_FIFO_AW 5
`endif

// [logic/sdac_fifo.v]
`include "sdac_map.vh"
// small word fifo, registered read data
module sdac_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clock,
    input wire srst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_r;
    reg [AW:0] rd_ptr_r;
    wire [AW:0] used = wr_ptr_r - rd_ptr_r;
    // the output register is a slot too, so depth is the whole capacity
    wire full = (used + {{AW{1'b0}}, out_valid} == DEPTH[AW:0]);
    wire empty = (used == {(AW+1){1'b0}});
    wire pop = !empty && (!out_valid || out_ready);
    assign in_ready = !full;
    // storage write, no reset needed on the array
    always @(posedge clock) begin
        if (in_valid && !full) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end
    // pointers and output register
    always @(posedge clock) begin
        if (srst) begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                out_data <= mem[rd_ptr_r[AW-1:0]];
                out_valid <= 1'b1;
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule // sdac_fifo

// [logic/sdac_core.v]
// Notes on behaviour
// - one write frame carries exactly one sixteen-bit word into the shifter
// - only the low 12 or 14 bits are data; the rest ignored
// - after frame falls, data is shifted in on each serial clock fall
// - load strobe level is sampled when the frame falls
// - strobe sampled low: dac register loads when the frame rises
// - strobe sampled high: no load at frame end; later strobe low loads
// - without readback, serial out repeats input sixteen clocks later
// - serial out changes shortly after serial clock falls
// - power-down never touches the dac register
// - readback enable low copies dac register into shifter next clock fall
// - during readback dac register bits leave on serial out per fall
// - readback word has its top two bits zero
// - clear falling edge forces output to ground level; registers kept
// - after clear rises, output reloads now if strobe low, else later
// - data field is unsigned straight binary
`include "sdac_map.vh"
module sdac_core (
    input wire clock,
    input wire srst,
    input wire resolution_14,
    input wire serial_clock,
    input wire host_transmit_frame,
    input wire serial_data_in,
    input wire load_output_n,
    input wire readback_enable_n,
    input wire output_clear_n,
    input wire power_down_n,
    output wire serial_data_out_o,
    output wire serial_data_out_oe_n,
    output reg [`SDAC_DATA_W-1:0] dac_code,
    output reg output_ground_sense,
    output reg powered_down,
    output wire word_valid,
    input wire word_ready,
    output wire [`SDAC_WORD_W-1:0] word_data,
    output wire word_overflow
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SHIFT = 3'b010;
    localparam ST_HELD = 3'b100;
    localparam DLY_W = 3;
    // the count is cut to the delay counter's width on purpose
    localparam [31:0] OUT_DLY_FULL = `SDAC_OUT_DELAY_CYC;
    localparam [DLY_W-1:0] OUT_DLY = OUT_DLY_FULL[DLY_W-1:0];

    // two-flop synchronisers for every pin input, one generate loop
    // flops start high, the idle level of the framing and control pins
    localparam NSYNC = 7;
    wire [NSYNC-1:0] pins_raw = {power_down_n, output_clear_n,
        readback_enable_n, load_output_n, serial_data_in,
        host_transmit_frame, serial_clock};
    reg [NSYNC-1:0] meta_r;
    reg [NSYNC-1:0] sync_r;
    reg [NSYNC-1:0] prev_r;
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clock) begin
                if (srst) begin
                    meta_r[gi] <= 1'b1;
                    sync_r[gi] <= 1'b1;
                    prev_r[gi] <= 1'b1;
                end else begin
                    meta_r[gi] <= pins_raw[gi];
                    sync_r[gi] <= meta_r[gi];
                    prev_r[gi] <= sync_r[gi];
                end
            end
        end
    endgenerate
    // synchronised pin levels
    wire sclk_s = sync_r[0];
    wire frame_s = sync_r[1];
    wire serial_data_in_s = sync_r[2];
    wire load_output_n_s = sync_r[3];
    wire readback_enable_n_s = sync_r[4];
    wire clr_s = sync_r[5];
    wire pd_s = sync_r[6];
    // edges, one clock behind the second flop; falls drive the shifter
    wire sclk_fall = prev_r[0] && !sclk_s;
    wire frame_fall = prev_r[1] && !frame_s;
    wire frame_rise = !prev_r[1] && frame_s;
    wire load_output_n_fall = prev_r[3] && !load_output_n_s;
    wire clr_fall = prev_r[5] && !clr_s;
    wire clr_rise = !prev_r[5] && clr_s;

    // frame, shifter and load state
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [`SDAC_WORD_W-1:0] shift_r;
    reg [`SDAC_WORD_W-1:0] dac_reg_r;
    reg [`SDAC_CNT_W-1:0] bit_cnt_r;
    reg auto_load_r;
    reg word_done_r;
    reg pending_r;
    reg cleared_r;
    reg rb_armed_r;
    reg sdo_r;
    reg sdo_next_r;
    reg [DLY_W-1:0] dly_r;
    reg overflow_r;
    wire fifo_in_ready;

    // frame state machine
    // a frame that rises early drops back to idle with no load
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (frame_fall) begin
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (frame_rise) begin
                    state_nxt = ST_IDLE;
                end else if (sclk_fall && bit_cnt_r == `SDAC_WORD_LAST) begin
                    state_nxt = ST_HELD; // extra clocks just pass through
                end
            end
            ST_HELD: begin
                if (frame_rise) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // data field from the received word, msb first, right-justified
    wire [`SDAC_DATA_W-1:0] field14 = dac_reg_r[`SDAC_DATA_W-1:0];
    wire [`SDAC_DATA_W-1:0] field = (resolution_14 == `SDAC_RES_14) ?
        field14 : {2'b00, field14[11:0]};
    wire in_frame = (state_r != ST_IDLE);
    wire rx_shift = sclk_fall && in_frame;
    wire rb_load = sclk_fall && rb_armed_r;
    // readback word has the two upper positions cleared
    wire [`SDAC_WORD_W-1:0] rb_word = {2'b00,
        dac_reg_r[`SDAC_WORD_W-3:0]};
    // a load into the dac register: frame end or strobe after the word
    wire load_auto = frame_rise && auto_load_r && word_done_r;
    wire load_strobe = pending_r && !load_output_n_s;
    wire word_end = frame_rise && word_done_r;

    // frame state and the strobe level caught at frame start
    always @(posedge clock) begin
        if (srst) begin
            state_r <= ST_IDLE;
            auto_load_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (frame_fall) begin
                auto_load_r <= !load_output_n_s;
            end
        end
    end

    // bit counter; falls past the sixteenth do not recount
    always @(posedge clock) begin
        if (srst) begin
            bit_cnt_r <= `SDAC_CNT_RST;
            word_done_r <= 1'b0;
        end else if (frame_fall) begin
            bit_cnt_r <= `SDAC_CNT_RST;
            word_done_r <= 1'b0;
        end else if (rx_shift && state_r == ST_SHIFT) begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == `SDAC_WORD_LAST) begin
                word_done_r <= 1'b1;
            end
        end
    end

    // readback arms on enable low, fires on next clock fall
    always @(posedge clock) begin
        if (srst) begin
            rb_armed_r <= 1'b0;
        end else if (!readback_enable_n_s && !rb_armed_r && prev_r[4]) begin
            rb_armed_r <= 1'b1;
        end else if (rb_load) begin
            rb_armed_r <= 1'b0;
        end
    end

    // shifter: msb leaves first, so out bit is the input of 16 falls ago
    // readback sends its msb at once, so that bit must not repeat
    always @(posedge clock) begin
        if (srst) begin
            shift_r <= `SDAC_WORD_RST;
            sdo_next_r <= 1'b0;
        end else if (rb_load) begin
            shift_r <= {rb_word[`SDAC_WORD_W-2:0], 1'b0};
            sdo_next_r <= rb_word[`SDAC_WORD_W-1];
        end else if (sclk_fall) begin
            sdo_next_r <= shift_r[`SDAC_WORD_W-1];
            if (rx_shift) begin
                shift_r <= {shift_r[`SDAC_WORD_W-2:0], serial_data_in_s};
            end else begin
                shift_r <= {shift_r[`SDAC_WORD_W-2:0], 1'b0};
            end
        end
    end

    // strobe-controlled update waits for the word, then load_output_n low
    always @(posedge clock) begin
        if (srst) begin
            pending_r <= 1'b0;
        end else if (word_end && !auto_load_r) begin
            pending_r <= 1'b1;
        end else if (load_strobe) begin
            pending_r <= 1'b0;
        end
    end

    // dac register: loaded at frame end or by the later strobe
    always @(posedge clock) begin
        if (srst) begin
            dac_reg_r <= `SDAC_WORD_RST;
        end else if (load_auto) begin
            dac_reg_r <= shift_r;
        end else if (load_strobe) begin
            dac_reg_r <= shift_r;
        end
    end

    // serial out appears a short delay after the sampled fall
    // a fall during the delay restarts it; falls are far apart anyway
    always @(posedge clock) begin
        if (srst) begin
            sdo_r <= 1'b0;
            dly_r <= {DLY_W{1'b0}};
        end else if (sclk_fall) begin
            dly_r <= OUT_DLY;
        end else if (dly_r != {DLY_W{1'b0}}) begin
            dly_r <= dly_r - 1'b1;
            if (dly_r == 3'h1) begin
                sdo_r <= sdo_next_r;
            end
        end
    end
    // open drain: pull low by enabling, release for a one
    assign serial_data_out_o = 1'b0;
    assign serial_data_out_oe_n = sdo_r;

    // power-down only gates the output stage, register untouched
    always @(posedge clock) begin
        if (srst) begin
            powered_down <= 1'b0;
        end else begin
            powered_down <= !pd_s;
        end
    end

    // clear grounds the output; the code freezes until the reload
    always @(posedge clock) begin
        if (srst) begin
            dac_code <= {`SDAC_DATA_W{1'b0}};
            cleared_r <= 1'b0;
            output_ground_sense <= 1'b0;
        end else begin
            if (clr_fall) begin
                cleared_r <= 1'b1;
            end else if (cleared_r && clr_s &&
                    (clr_rise ? !load_output_n_s : load_output_n_fall)) begin
                cleared_r <= 1'b0;
            end
            output_ground_sense <= cleared_r || clr_fall;
            if (!cleared_r && !clr_fall) begin
                dac_code <= field;
            end
        end
    end

    // each completed word is queued for the user side; one that finds the queue full is dropped and sets overflow
    always @(posedge clock) begin
        if (srst) begin
            overflow_r <= 1'b0;
        end else if (word_end && !fifo_in_ready) begin
            overflow_r <= 1'b1;
        end
    end
    assign word_overflow = overflow_r;

    // word queue; the user side pops at its own pace
    sdac_fifo #(
        .WIDTH(`SDAC_WORD_W),
        .DEPTH(`SDAC_FIFO_DEPTH),
        .AW(`SDAC_FIFO_AW)
    ) u_fifo (
        .clock(clock),
        .srst(srst),
        .in_valid(word_end),
        .in_ready(fifo_in_ready),
        .in_data(shift_r),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );
endmodule // sdac_core

// [test/sdac_core_sva.sv]
`include "sdac_map.vh"
module sdac_core_sva (
    input wire clock,
    input wire srst,
    input wire resolution_14,
    input wire serial_clock,
    input wire load_output_n,
    input wire output_clear_n,
    input wire power_down_n,
    input wire serial_data_out_oe_n,
    input wire [`SDAC_DATA_W-1:0] dac_code,
    input wire output_ground_sense,
    input wire powered_down,
    input wire word_valid,
    input wire word_ready,
    input wire [`SDAC_WORD_W-1:0] word_data
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // clear lifted while the strobe stays low
    sequence clr_up_load_output_n_low;
        $rose(output_clear_n) ##0 !load_output_n [*6];
    endsequence
    // power and clear paths
    chk_power_keep: assert property (
        $changed(powered_down) |-> $stable(dac_code))
        else $error("dac code moved with power-down");
    chk_power_enter: assert property (
        $fell(power_down_n) |-> ##[1:5] powered_down)
        else $error("power-down not entered");
    chk_clear_ground: assert property (
        $fell(output_clear_n) |-> ##[1:5] output_ground_sense)
        else $error("clear did not ground the output");
    chk_clear_release: assert property (
        clr_up_load_output_n_low |-> ##[0:4] !output_ground_sense)
        else $error("output not reloaded after clear");
    chk_clear_wait: assert property (
        load_output_n [*5] ##0 output_ground_sense |=> output_ground_sense)
        else $error("output reloaded without strobe");
    // data path; sync delay means sdo moves 4 or 5 clocks after a fall
    chk_top_zero: assert property (
        $changed(dac_code) && !resolution_14 |-> dac_code[13:12] == 2'b00)
        else $error("top bits set in 12-bit mode");
    chk_sdo_fall: assert property (
        $changed(serial_data_out_oe_n)
        |-> !$past(serial_clock, 4) || !$past(serial_clock, 5))
        else $error("serial out moved away from a fall");
    chk_word_hold: assert property (
        word_valid && !word_ready |=> word_valid && $stable(word_data))
        else $error("word dropped before pop");
endmodule // sdac_core_sva
bind sdac_core sdac_core_sva u_sva (.clock, .srst, .resolution_14,
    .serial_clock, .load_output_n, .output_clear_n, .power_down_n,
    .serial_data_out_oe_n, .dac_code, .output_ground_sense, .powered_down,
    .word_valid, .word_ready, .word_data);

// [test/sdac_host.sv]
module sdac_host (
    output logic serial_clock,
    output logic host_transmit_frame,
    output logic serial_data_in,
    output logic readback_enable_n,
    input wire sdo_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: clock parked high, no frame
    initial begin
        serial_clock = 1'b1;
        host_transmit_frame = 1'b1;
        serial_data_in = 1'b0;
        readback_enable_n = 1'b1;
    end
    // one frame; rx catches sdo one fall late, plus a final sample
    task automatic xfer(input logic [15:0] w, input logic rb, input int n,
                        output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        #2; // step off the clock edge before touching a pin
        if (rb) readback_enable_n = 1'b0;
        else host_transmit_frame = 1'b0;
        #40;
        for (i = 0; i < n; i++) begin
            serial_data_in = w[15 - (i % 16)];
            #32 serial_clock = 1'b0;
            if (i > 0) rx = {rx[14:0], sdo_pin};
            #32 serial_clock = 1'b1;
        end
        #32 rx = {rx[14:0], sdo_pin};
        serial_data_in = ~serial_data_in; // data no longer valid
        host_transmit_frame = 1'b1;
        readback_enable_n = 1'b1;
        #40;
    endtask
endmodule // sdac_host

// [test/tb.sv]
`include "sdac_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, srst, resolution_14, load_output_n, output_clear_n;
    logic power_down_n, word_ready;
    wire serial_clock, host_transmit_frame, serial_data_in;
    wire readback_enable_n, serial_data_out_o, serial_data_out_oe_n;
    wire output_ground_sense, powered_down, word_valid, word_overflow;
    wire [`SDAC_DATA_W-1:0] dac_code;
    wire [`SDAC_WORD_W-1:0] word_data;
    // open-drain line with its pull-up
    wire sdo_pin = serial_data_out_oe_n ? 1'b1 : serial_data_out_o;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int i;
    logic [15:0] rx;
    // rows: resolution, word sent, code expected
    logic [30:0] rows [5] = '{{1'b1, 16'hffff, 14'h3fff},
        {1'b1, 16'h8001, 14'h0001}, {1'b0, 16'h5abc, 14'h0abc},
        {1'b1, 16'h2345, 14'h2345}, {1'b0, 16'hf123, 14'h0123}};
    sdac_core DUT (.clock, .srst, .resolution_14, .serial_clock,
        .host_transmit_frame, .serial_data_in, .load_output_n,
        .readback_enable_n, .output_clear_n, .power_down_n,
        .serial_data_out_o, .serial_data_out_oe_n, .dac_code,
        .output_ground_sense, .powered_down, .word_valid, .word_ready,
        .word_data, .word_overflow);
    sdac_host u_host (.serial_clock, .host_transmit_frame, .serial_data_in,
        .readback_enable_n, .sdo_pin);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // let load and sync latency pass, sampling away from the edge
    task automatic settle;
        repeat (8) @(negedge clock);
    endtask
    task automatic pop(input logic [15:0] exp);
        int t;
        @(negedge clock); // never sample on the edge of the last pop
        for (t = 0; t < 50 && word_valid !== 1'b1; t++) @(negedge clock);
        check({15'h0, word_valid}, 16'h0001);
        check(word_data, exp);
        @(posedge clock) word_ready <= 1'b1;
        @(posedge clock) word_ready <= 1'b0;
    endtask
    // hang guard, well above the expected run
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            stop_test;
        end
    end
    initial begin
        srst = 1'b1;
        resolution_14 = 1'b1;
        load_output_n = 1'b0;
        output_clear_n = 1'b1;
        power_down_n = 1'b1;
        word_ready = 1'b0;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        settle;
        for (i = 0; i < 5; i++) begin
            @(posedge clock) resolution_14 <= rows[i][30];
            u_host.xfer(rows[i][29:14], 1'b0, 16, rx);
            settle;
            check({2'b00, dac_code}, {2'b00, rows[i][13:0]});
            pop(rows[i][29:14]);
        end
        $display("table done");
        u_host.xfer(16'hc3a5, 1'b0, 16, rx);
        u_host.xfer(16'h1e0f, 1'b0, 16, rx);
        check(rx, 16'hc3a5);
        pop(16'hc3a5);
        pop(16'h1e0f);
        @(posedge clock) load_output_n <= 1'b1;
        u_host.xfer(16'h0555, 1'b0, 16, rx);
        settle;
        check({2'b00, dac_code}, 16'h0e0f);
        @(posedge clock) load_output_n <= 1'b0;
        settle;
        check({2'b00, dac_code}, 16'h0555);
        pop(16'h0555);
        $display("daisy and strobe done");
        @(posedge clock) resolution_14 <= 1'b1;
        u_host.xfer(16'hffff, 1'b0, 16, rx);
        pop(16'hffff);
        u_host.xfer(16'h0000, 1'b1, 16, rx);
        check(rx, 16'h3fff);
        @(posedge clock) load_output_n <= 1'b1;
        @(posedge clock) output_clear_n <= 1'b0;
        settle;
        check({15'h0, output_ground_sense}, 16'h0001);
        @(posedge clock) output_clear_n <= 1'b1;
        settle;
        check({15'h0, output_ground_sense}, 16'h0001);
        @(posedge clock) load_output_n <= 1'b0;
        settle;
        check({15'h0, output_ground_sense}, 16'h0000);
        check({2'b00, dac_code}, 16'h3fff);
        @(posedge clock) output_clear_n <= 1'b0;
        settle;
        @(posedge clock) output_clear_n <= 1'b1;
        settle;
        check({15'h0, output_ground_sense}, 16'h0000);
        @(posedge clock) power_down_n <= 1'b0;
        settle;
        check({15'h0, powered_down}, 16'h0001);
        @(posedge clock) power_down_n <= 1'b1;
        settle;
        u_host.xfer(16'h0000, 1'b1, 16, rx);
        check(rx, 16'h3fff);
        $display("readback clear power done");
        u_host.xfer(16'h1234, 1'b0, 8, rx);
        settle;
        check({2'b00, dac_code}, 16'h3fff);
        check({15'h0, word_valid}, 16'h0000);
        // fill past depth while the reader stalls, then drain
        for (i = 0; i < 33; i++) u_host.xfer(16'h0100 + i[15:0], 1'b0, 16, rx);
        settle;
        check({15'h0, word_overflow}, 16'h0001);
        for (i = 0; i < 32; i++) pop(16'h0100 + i[15:0]);
        settle;
        check({15'h0, word_valid}, 16'h0000);
        $display("fifo done");
        @(posedge clock) srst <= 1'b1;
        settle;
        check({2'b00, dac_code}, 16'h0000);
        check({15'h0, word_overflow}, 16'h0000);
        @(posedge clock) srst <= 1'b0;
        $display("reset done");
        stop_test;
    end
endmodule // tb
